/* File: logic/ulsf_line_status.sv */
`include "ulsf_consts.svh"
`default_nettype none
module ulsf_line_status (
  input wire logic ref_clk, // System clock, 20 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  output logic irq, // Level interrupt.
  input wire logic rx_pin, // Serial receive line, async.
  input wire logic rx_char_valid, // Receiver finished a character.
  input wire logic [7:0] rx_char, // Received character.
  input wire logic rx_parity_err, // Parity error of rx_char.
  input wire logic rx_frame_err, // Missing stop bit of rx_char.
  output logic tx_char_valid, // Character offered to shifter.
  output logic [7:0] tx_char, // Character offered to shifter.
  input wire logic tx_char_ready, // Shifter takes the character.
  input wire logic tx_shift_busy // Shifter still holds a character.
);
  logic [1:0] ctrl_q;
  logic [2:0] imsk_q, ists_q;
  logic [31:0] hrdata_q;
  logic dph_wr_q;
  logic [7:0] dph_addr_q;
  logic [7:0] tx_mem [0:31];
  logic [10:0] rx_mem [0:31];
  logic [4:0] tx_wr_q, tx_rd_q, rx_wr_q, rx_rd_q;
  logic [5:0] tx_cnt_q, rx_cnt_q, err_cnt_q;
  logic oe_q, head_ack_q, thre_q, rx_s1_q, rx_s2_q;
  logic [11:0] brk_cnt_q;
  ulsf_pkg::ulsf_brk_state_t brk_q;
  logic aph, rd_lsr, rd_rxd, wr_ctrl, flush, fifo_en;
  logic tx_full, tx_push, tx_pop, rx_full, rx_push_req, rx_push, rx_pop, overrun;
  logic brk_push, head_flag, new_flag, thre, temt;
  logic [10:0] rx_entry, rx_head;
  logic [7:0] line_status;
  logic [31:0] rd_mux;

  // Address phase of a transfer to this slave.
  assign aph = hsel & htrans[1] & hready;
  assign rd_lsr = aph & ~hwrite & (haddr[7:0] == `ULSF_A_LSR);
  assign rd_rxd = aph & ~hwrite & (haddr[7:0] == `ULSF_A_RXD);
  assign wr_ctrl = dph_wr_q & (dph_addr_q == `ULSF_A_CTRL);
  assign fifo_en = ctrl_q[`ULSF_CTRL_FIFO];
  // A change of FIFO mode empties both queues.
  assign flush = wr_ctrl & (hwdata[`ULSF_CTRL_FIFO] != fifo_en);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Data phase bookkeeping for writes.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= 8'h00;
    end
    else
    begin
      dph_wr_q <= aph & hwrite;
      dph_addr_q <= haddr[7:0];
    end
  end

  // Read data is latched at the address phase edge, with its side effects.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      hrdata_q <= 32'h00000000;
    else if (aph & ~hwrite)
      hrdata_q <= rd_mux;
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `ULSF_A_LSR: rd_mux = {24'h000000, line_status};
      `ULSF_A_CTRL: rd_mux = {30'h00000000, ctrl_q};
      `ULSF_A_RXD: rd_mux = {24'h000000, rx_head[7:0]};
      `ULSF_A_ISTS: rd_mux = {29'h00000000, ists_q};
      `ULSF_A_IMSK: rd_mux = {29'h00000000, imsk_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Control and mask registers.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `ULSF_CTRL_RST;
      imsk_q <= `ULSF_IMSK_RST;
    end
    else if (dph_wr_q)
    begin
      if (dph_addr_q == `ULSF_A_CTRL)
        ctrl_q <= hwdata[1:0];
      if (dph_addr_q == `ULSF_A_IMSK)
        imsk_q <= hwdata[2:0];
    end
  end

  // Transmit queue: depth one without FIFOs, a full FIFO otherwise.
  assign tx_full = fifo_en ? (tx_cnt_q == `ULSF_DEPTH) : (tx_cnt_q != 6'h00);
  assign tx_push = dph_wr_q & (dph_addr_q == `ULSF_A_TXD) & ~tx_full & ~flush;
  assign tx_pop = tx_char_valid & tx_char_ready;
  assign tx_char_valid = (tx_cnt_q != 6'h00);
  assign tx_char = tx_mem[tx_rd_q];

  always_ff @(posedge ref_clk)
  begin
    if (tx_push)
      tx_mem[tx_wr_q] <= hwdata[7:0];
  end

  // Transmit pointers and fill count.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_wr_q <= 5'h00;
      tx_rd_q <= 5'h00;
      tx_cnt_q <= 6'h00;
    end
    else if (flush)
    begin
      tx_wr_q <= 5'h00;
      tx_rd_q <= 5'h00;
      tx_cnt_q <= 6'h00;
    end
    else
    begin
      if (tx_push)
        tx_wr_q <= tx_wr_q + 5'h01;
      if (tx_pop)
        tx_rd_q <= tx_rd_q + 5'h01;
      if (tx_push & ~tx_pop)
        tx_cnt_q <= tx_cnt_q + 6'h01;
      else if (tx_pop & ~tx_push)
        tx_cnt_q <= tx_cnt_q - 6'h01;
    end
  end

  assign thre = (tx_cnt_q == 6'h00);
  assign temt = thre & ~tx_shift_busy;

  // Receive line synchroniser.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  assign brk_push = (brk_q == ulsf_pkg::BRK_COUNT) & ~rx_s2_q &
                    (brk_cnt_q == 12'(`ULSF_FRAME_CYC - 1));

  // Counts synchronised low samples. The count starts at one in idle, so the push
  // lands on the last sample of the frame time.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      brk_q <= ulsf_pkg::BRK_IDLE;
      brk_cnt_q <= 12'h000;
    end
    else
    begin
      case (brk_q)
        ulsf_pkg::BRK_IDLE:
        begin
          brk_cnt_q <= 12'h001;
          if (~rx_s2_q)
            brk_q <= ulsf_pkg::BRK_COUNT;
        end
        ulsf_pkg::BRK_COUNT:
        begin
          brk_cnt_q <= brk_cnt_q + 12'h001;
          if (rx_s2_q)
            brk_q <= ulsf_pkg::BRK_IDLE;
          else if (brk_push)
            brk_q <= ulsf_pkg::BRK_HELD;
        end
        ulsf_pkg::BRK_HELD:
        begin
          if (rx_s2_q)
            brk_q <= ulsf_pkg::BRK_IDLE;
        end
        default: brk_q <= ulsf_pkg::BRK_IDLE;
      endcase
    end
  end

  // Receive entry is {break, framing, parity, data}.
  assign rx_entry = {brk_push, rx_char_valid & rx_frame_err, rx_char_valid & rx_parity_err,
                     rx_char_valid ? rx_char : 8'h00};
  assign rx_head = rx_mem[rx_rd_q];
  assign new_flag = |rx_entry[10:8];
  assign head_flag = |rx_head[10:8];
  assign rx_full = fifo_en ? (rx_cnt_q == `ULSF_DEPTH) : (rx_cnt_q != 6'h00);
  assign rx_push_req = (rx_char_valid | brk_push) & ~flush;
  assign overrun = rx_push_req & rx_full;
  assign rx_push = rx_push_req & ~rx_full;
  assign rx_pop = rd_rxd & (rx_cnt_q != 6'h00) & ~flush;

  always_ff @(posedge ref_clk)
  begin
    if (rx_push)
      rx_mem[rx_wr_q] <= rx_entry;
  end

  // Receive pointers, fill count and count of flagged entries.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_wr_q <= 5'h00;
      rx_rd_q <= 5'h00;
      rx_cnt_q <= 6'h00;
      err_cnt_q <= 6'h00;
    end
    else if (flush)
    begin
      rx_wr_q <= 5'h00;
      rx_rd_q <= 5'h00;
      rx_cnt_q <= 6'h00;
      err_cnt_q <= 6'h00;
    end
    else
    begin
      if (rx_push)
        rx_wr_q <= rx_wr_q + 5'h01;
      if (rx_pop)
        rx_rd_q <= rx_rd_q + 5'h01;
      if (rx_push & ~rx_pop)
        rx_cnt_q <= rx_cnt_q + 6'h01;
      else if (rx_pop & ~rx_push)
        rx_cnt_q <= rx_cnt_q - 6'h01;
      if ((rx_push & new_flag) & ~(rx_pop & head_flag))
        err_cnt_q <= err_cnt_q + 6'h01;
      else if ((rx_pop & head_flag) & ~(rx_push & new_flag))
        err_cnt_q <= err_cnt_q - 6'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      oe_q <= 1'b0;
    else if (overrun)
      oe_q <= 1'b1;
    else if (rd_lsr)
      oe_q <= 1'b0;
  end

  // head flags read once.
  // A read hides the head's flags until another character reaches the head.
  // An empty queue has no head, so a read of it arms nothing.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      head_ack_q <= 1'b0;
    else if (rx_pop | flush | (rx_push & (rx_cnt_q == 6'h00)))
      head_ack_q <= 1'b0;
    else if (rd_lsr & (rx_cnt_q != 6'h00))
      head_ack_q <= 1'b1;
  end

  always_comb
  begin
    line_status = 8'h00;
    line_status[`ULSF_DR] = (rx_cnt_q != 6'h00);
    line_status[`ULSF_OE] = oe_q;
    line_status[`ULSF_PE] = line_status[`ULSF_DR] & ~head_ack_q & rx_head[8];
    line_status[`ULSF_FE] = line_status[`ULSF_DR] & ~head_ack_q & rx_head[9];
    line_status[`ULSF_BI] = line_status[`ULSF_DR] & ~head_ack_q & rx_head[10];
    line_status[`ULSF_THRE] = thre;
    line_status[`ULSF_TEMT] = temt;
    line_status[`ULSF_FERR] = fifo_en & (err_cnt_q != 6'h00);
  end

  // Interrupt status: set by events, cleared by writing one; set wins.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ists_q <= 3'h0;
      thre_q <= 1'b1;
    end
    else
    begin
      thre_q <= thre;
      ists_q <= (ists_q & ~((dph_wr_q & (dph_addr_q == `ULSF_A_ISTS)) ? hwdata[2:0] : 3'h0))
                | {thre & ~thre_q, overrun | (rx_push & new_flag), rx_push};
    end
  end

  assign irq = (|(ists_q & imsk_q)) | (thre & ctrl_q[`ULSF_CTRL_THRIE]);


  // Status flag checks; reset holds them off.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_temt_set: assert property ((tx_cnt_q == 6'h00) && !tx_shift_busy |-> line_status[6])
    else $error("Transmit empty not set with both stages empty.");
  a_temt_clr: assert property (tx_char_valid || tx_shift_busy |-> !line_status[6])
    else $error("Transmit empty set while a character is held.");
  a_thre_load: assert property (tx_push && !tx_pop |=> !line_status[5])
    else $error("Holding empty not cleared by a load.");
  a_thre_move: assert property (tx_pop && tx_cnt_q == 6'h01 && !tx_push |=> line_status[5])
    else $error("Holding empty not set after the move.");
  a_thre_irq: assert property (line_status[5] && ctrl_q[1] |-> irq)
    else $error("Holding empty interrupt missing.");
  a_brk_once: assert property (brk_push |=> !brk_push [*8])
    else $error("Second break character for one break.");
  a_brk_flag: assert property (brk_push && rx_cnt_q == 6'h00 && !flush |=> line_status[4])
    else $error("Break bit not reported.");
  a_ovr_keep: assert property (overrun && !rx_pop |=> oe_q && $stable(rx_cnt_q))
    else $error("Overrun altered the FIFO or missed the flag.");
  a_dr_push: assert property (rx_push |=> line_status[0])
    else $error("Data ready missing after a stored character.");
  a_ferr_set: assert property (fifo_en && rx_push && new_flag |=> line_status[7])
    else $error("FIFO error bit missing.");
  a_oe_read: assert property (rd_lsr && !overrun |=> !oe_q)
    else $error("Overrun not cleared by a status read.");
  // Receive flag, clearing and transmit FIFO checks.
  a_pe_head: assert property (rx_push && rx_cnt_q == 6'h00 && rx_entry[8] |=> line_status[2])
    else $error("Parity error of the new head not reported.");
  a_fe_head: assert property (rx_push && rx_cnt_q == 6'h00 && rx_entry[9] |=> line_status[3])
    else $error("Framing error of the new head not reported.");
  a_ferr_drop: assert property (rx_pop && head_flag && err_cnt_q == 6'h01 && !(rx_push && new_flag) |=> !line_status[7])
    else $error("FIFO error bit left set with no flagged character.");
  a_dr_clear: assert property (rx_pop && rx_cnt_q == 6'h01 && !rx_push |=> !line_status[0])
    else $error("Data ready left set on an empty queue.");
  a_temt_fifo: assert property (fifo_en && tx_cnt_q != 6'h00 |-> !line_status[6])
    else $error("Transmit empty set with the FIFO holding data.");
  a_thre_fifo: assert property (fifo_en && tx_push |=> !line_status[5])
    else $error("Holding empty not cleared by a FIFO write.");
  a_err_read: assert property (rd_lsr && rx_cnt_q != 6'h00 |=> !line_status[2] && !line_status[3] && !line_status[4])
    else $error("Error bits not cleared by a status read.");

  // Main scenarios.
  c_overrun: cover property (overrun);
  c_flag_head: cover property (fifo_en && rx_push && new_flag);
  c_tx_drain: cover property (fifo_en && tx_pop && tx_cnt_q == 6'h01);
  c_break: cover property (brk_push ##1 rd_lsr);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: logic/ulsf_consts.svh */
// Behaviour
// - Non-FIFO: transmit empty when holding and shift empty.
// - Transmit empty clears while any character is held.
// - FIFO mode: transmit empty needs FIFO and shifter empty.
// - Holding empty sets when character moves to shifter.
// - Holding empty clears when CPU loads holding register.
// - Holding empty with its enable raises interrupt.
// - FIFO mode: holding empty follows transmit FIFO emptiness.
// - Break bit when input low one frame.
// - One break character per break condition.
// - Framing error bit, tied to FIFO head.
// - Parity error bit, tied to FIFO head.
// - Overrun bit when character arrives into full FIFO.
// - Overrun character is not stored in FIFO.
// - Data ready while received data remains.
// - Error and ready bits reset to zero.
// - FIFO error bit while any flagged character held.
`ifndef ULSF_CONSTS_SVH
`define ULSF_CONSTS_SVH
`define ULSF_A_LSR 8'h00
`define ULSF_A_CTRL 8'h04
`define ULSF_A_TXD 8'h08
`define ULSF_A_RXD 8'h0c
`define ULSF_A_ISTS 8'h10
`define ULSF_A_IMSK 8'h14
`define ULSF_CTRL_FIFO 0
`define ULSF_CTRL_THRIE 1
`define ULSF_CTRL_RST 2'h0
`define ULSF_IMSK_RST 3'h0
`define ULSF_IRQ_RXRDY 0
`define ULSF_IRQ_LERR 1
`define ULSF_IRQ_THRE 2
`define ULSF_DR 0
`define ULSF_OE 1
`define ULSF_PE 2
`define ULSF_FE 3
`define ULSF_BI 4
`define ULSF_THRE 5
`define ULSF_TEMT 6
`define ULSF_FERR 7
`define ULSF_DEPTH 6'h20
`define ULSF_CLK_NS 50
`define ULSF_FRAME_NS 86800
`define ULSF_FRAME_CYC ((`ULSF_FRAME_NS + `ULSF_CLK_NS - 1) / `ULSF_CLK_NS)
`endif

/* File: logic/ulsf_pkg.sv */
`default_nettype none
package ulsf_pkg;
  // States of the break detector.
  typedef enum logic [1:0] {BRK_IDLE, BRK_COUNT, BRK_HELD} ulsf_brk_state_t;
endpackage
`default_nettype wire

/* File: sim/ulsf_shift_model.sv */
`default_nettype none
module ulsf_shift_model #(
  parameter int unsigned SHIFT_CYC = 20
) (
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic stall, // Holds the shifter off the queue.
  input wire logic tx_char_valid, // Character offered.
  input wire logic [7:0] tx_char, // Offered character.
  output logic tx_char_ready, // Shifter takes the character.
  output logic tx_shift_busy, // Shifter holds a character.
  output logic [7:0] last_char // Last character taken.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // The shifter accepts only when idle and not stalled by the bench.
  assign tx_char_ready = !stall && (cnt_q == 8'h00);
  assign tx_shift_busy = (cnt_q != 8'h00);
  // Counts down one character time after each take.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 8'h00;
      last_char <= 8'h00;
    end
    else if (tx_char_valid && tx_char_ready)
    begin
      cnt_q <= 8'(SHIFT_CYC);
      last_char <= tx_char;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: sim/ulsf_line_status_tb_top.sv */
`include "ulsf_consts.svh"
`default_nettype none
module ulsf_line_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, hwrite = 1'b0, rx_pin = 1'b1, rx_char_valid = 1'b0;
  logic rx_parity_err = 1'b0, rx_frame_err = 1'b0, stall = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [7:0] rx_char = 8'h00, tx_char, last_char;
  logic hreadyout, hresp, irq, tx_char_valid, tx_char_ready, tx_shift_busy;
  int errors = 0, total_checks = 0, cycles = 0;

  ulsf_line_status ulsf_line_status_i (.ref_clk(ref_clk), .rst(rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .rx_pin(rx_pin), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
    .tx_char_valid(tx_char_valid), .tx_char(tx_char), .tx_char_ready(tx_char_ready),
    .tx_shift_busy(tx_shift_busy));
  ulsf_shift_model ulsf_shift_model_i (.ref_clk(ref_clk), .rst(rst), .stall(stall),
    .tx_char_valid(tx_char_valid), .tx_char(tx_char), .tx_char_ready(tx_char_ready),
    .tx_shift_busy(tx_shift_busy), .last_char(last_char));

  // Free-running 20 MHz clock.
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short after a generous cycle ceiling.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  // One single AHB transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
    // One idle edge lets a write land before any output is looked at.
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // Receiver logic delivers one character with its error flags.
  task automatic rx(input logic [7:0] c, input logic pe, input logic fe);
    rx_char <= c;
    rx_parity_err <= pe;
    rx_frame_err <= fe;
    rx_char_valid <= 1'b1;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`ULSF_A_LSR, 32'h60);
    rd(32'h40, 32'h0);
    $display("test reset done");
    wr(`ULSF_A_CTRL, 32'h2);
    chk({31'h0, irq}, 32'h1);
    stall <= 1'b1;
    wr(`ULSF_A_TXD, 32'h5a);
    rd(`ULSF_A_LSR, 32'h00);
    chk({31'h0, irq}, 32'h0);
    stall <= 1'b0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    rd(`ULSF_A_LSR, 32'h20);
    repeat (30) @(posedge ref_clk);
    rd(`ULSF_A_LSR, 32'h60);
    chk({24'h0, last_char}, 32'h5a);
    $display("test single transmit done");
    wr(`ULSF_A_CTRL, 32'h0);
    rx(8'h3c, 1'b1, 1'b0);
    rd(`ULSF_A_LSR, 32'h65);
    rd(`ULSF_A_LSR, 32'h61);
    rd(`ULSF_A_RXD, 32'h3c);
    rd(`ULSF_A_LSR, 32'h60);
    rx(8'h11, 1'b0, 1'b0);
    rx(8'h22, 1'b0, 1'b0);
    rd(`ULSF_A_LSR, 32'h63);
    rd(`ULSF_A_RXD, 32'h11);
    rd(`ULSF_A_LSR, 32'h60);
    $display("test single receive done");
    wr(`ULSF_A_CTRL, 32'h1);
    rx(8'h77, 1'b0, 1'b1);
    wr(`ULSF_A_IMSK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`ULSF_A_ISTS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(`ULSF_A_ISTS, 32'h6);
    rd(`ULSF_A_LSR, 32'he9);
    rd(`ULSF_A_RXD, 32'h77);
    rd(`ULSF_A_LSR, 32'h60);
    rx_pin <= 1'b0;
    repeat (2 * `ULSF_FRAME_CYC + 100) @(posedge ref_clk);
    rx_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`ULSF_A_LSR, 32'hf1);
    rd(`ULSF_A_RXD, 32'h00);
    rd(`ULSF_A_LSR, 32'h60);
    $display("test queued receive done");
    stall <= 1'b1;
    wr(`ULSF_A_TXD, 32'ha1);
    wr(`ULSF_A_TXD, 32'ha2);
    rd(`ULSF_A_LSR, 32'h00);
    stall <= 1'b0;
    repeat (100) @(posedge ref_clk);
    rd(`ULSF_A_LSR, 32'h60);
    chk({24'h0, last_char}, 32'ha2);
    $display("test queued transmit done");
    summarize();
  end
endmodule
`default_nettype wire
